// ===== dcpp_consts.svh
// register offsets, field positions and reset values of the charge port block
`ifndef DCPP_CONSTS_SVH
`define DCPP_CONSTS_SVH

// number of downstream ports
`define DCPP_PORT_COUNT        3
// configuration register offsets
`define DCPP_CHARGE_EN_OFFSET  8'hd0
`define DCPP_STATUS_OFFSET     8'hd1
// first mask bit that belongs to a port (port 1)
`define DCPP_FIRST_PORT_BIT    1
// reset values
`define DCPP_CHARGE_EN_RESET   8'h00
`define DCPP_RDATA_RESET       8'h00
// status register field positions
`define DCPP_STAT_POWER_LSB    0
`define DCPP_STAT_FAULT_LSB    4
`define DCPP_STAT_CONFIG_BIT   7

`endif

// ===== dcpp_pkg.sv
// types shared by the charge port power control design
package dcpp_pkg;

   // configuration phase of the hub
   typedef enum logic {
      DCPP_CONFIGURING,
      DCPP_CONFIGURED
   } dcpp_phase_type;

   // who currently owns a port power output
   typedef enum logic {
      DCPP_OWNER_CHARGE,
      DCPP_OWNER_HUB
   } dcpp_owner_type;

endpackage : dcpp_pkg

// ===== dcpp_port_cell.sv
// one downstream port: power ownership, overcurrent latch, charging answer
`timescale 1ns/1ns

module dcpp_port_cell (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic reset_n,
   // configuration state
   input  wire logic configured,
   input  wire logic charge_role,
   // hub logic side
   input  wire logic hub_port_power_feature,
   input  wire logic hub_port_power_request,
   // port pins and device query
   input  wire logic overcurrent_sense_n,
   input  wire logic charge_query,
   // outputs
   output logic      port_power_out,
   output logic      overcurrent_fault,
   output logic      charge_ack
);

   dcpp_pkg::dcpp_owner_type owner;
   logic                     power_d;
   logic                     power_q;
   logic                     fault_q;
   logic                     ack_q;

   // feature set means the hub logic owns power, clear means charging logic
   assign owner = hub_port_power_feature ? dcpp_pkg::DCPP_OWNER_HUB
                                         : dcpp_pkg::DCPP_OWNER_CHARGE;

   // overcurrent seen on a configured charging port while charging logic owns power latches until reset
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         fault_q <= 1'b0;
      end else if (configured && charge_role && !overcurrent_sense_n &&
                   owner == dcpp_pkg::DCPP_OWNER_CHARGE) begin
         fault_q <= 1'b1;
      end
   end

   // next power value: nothing before configuration, overcurrent always wins
   always_comb begin
      power_d = 1'b0;
      if (!configured) begin
         power_d = 1'b0;
      end else if (!overcurrent_sense_n || fault_q) begin
         power_d = 1'b0;
      end else if (owner == dcpp_pkg::DCPP_OWNER_HUB) begin
         power_d = hub_port_power_request;
      end else begin
         power_d = charge_role;
      end
   end

   // registered power output
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         power_q <= 1'b0;
      end else begin
         power_q <= power_d;
      end
   end

   // only a charging port answers a query; others stay silent
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= charge_query && charge_role && configured;
      end
   end

   assign port_power_out    = power_q;
   assign overcurrent_fault = fault_q;
   assign charge_ack        = ack_q;

endmodule : dcpp_port_cell

// ===== dcpp_charge_port_ctrl.sv
// downstream charge port power control: config register and per-port cells
`timescale 1ns/1ns
`include "dcpp_consts.svh"

// Function
// - each downstream port can be set on its own as charging or standard.
// - a port's role is frozen once configuration completes.
// - a charging port acknowledges a charging query; others never answer.
// - on a charging port the charging logic governs port power.
// - charging logic turns port power on when configuration completes.
// - overcurrent under charging control turns power off until reset.
// - after enumeration the hub logic takes port power back.
// - feature 1 gives power to the hub logic, feature 0 to charging logic.
// - overcurrent turns port power off whoever owns it.
// - charge enables come only from serial config writes in the config phase.
// - the mask at d0 holds one bit per port, port 1 at bit 1 and upward.
// - every charging enabled port drives its port power bit on after configuration while charging logic owns it and no overcurrent or fault is seen.
// - the 3.3 V regulator enable is off in reset and turns on at the first clock edge after release.
module dcpp_charge_port_ctrl #(
   parameter int PORTS = `DCPP_PORT_COUNT
) (
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             reset_n,
   // serial configuration register port
   input  wire logic             cfg_wr_en,
   input  wire logic             cfg_rd_en,
   input  wire logic [7:0]       cfg_addr,
   input  wire logic [7:0]       cfg_wdata,
   output logic      [7:0]       cfg_rdata,
   input  wire logic             cfg_done,
   // hub logic
   input  wire logic [PORTS-1:0] hub_port_power_feature,
   input  wire logic [PORTS-1:0] hub_port_power_request,
   // downstream port pins and charging queries
   input  wire logic [PORTS-1:0] overcurrent_sense_n,
   input  wire logic [PORTS-1:0] charge_query,
   output logic      [PORTS-1:0] port_power_out,
   output logic      [PORTS-1:0] charge_ack,
   output logic      [PORTS-1:0] charge_port_role,
   // regulator control
   output logic                  reg33_enable
);

   dcpp_pkg::dcpp_phase_type phase_q;
   logic [7:0]               charge_port_enable_mask_q;
   logic [7:0]               cfg_rdata_q;
   logic [7:0]               status_word;
   logic [PORTS-1:0]         role;
   logic [PORTS-1:0]         fault;
   logic                     configured;
   logic                     reg33_q;
   logic                     mask_wr;

   assign configured = (phase_q == dcpp_pkg::DCPP_CONFIGURED);

   // configuration phase: leaves configuring once and stays until reset
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         phase_q <= dcpp_pkg::DCPP_CONFIGURING;
      end else begin
         unique case (phase_q)
            dcpp_pkg::DCPP_CONFIGURING: begin
               if (cfg_done) begin
                  phase_q <= dcpp_pkg::DCPP_CONFIGURED;
               end
            end
            dcpp_pkg::DCPP_CONFIGURED: begin
               phase_q <= dcpp_pkg::DCPP_CONFIGURED;
            end
         endcase
      end
   end

   // mask writes count only during the configuration phase
   assign mask_wr = cfg_wr_en && !configured &&
                    cfg_addr == `DCPP_CHARGE_EN_OFFSET;

   // charge enable mask register; bit 0 is unused and stays zero
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         charge_port_enable_mask_q <= `DCPP_CHARGE_EN_RESET;
      end else if (mask_wr) begin
         charge_port_enable_mask_q <= {cfg_wdata[7:1], 1'b0};
      end
   end

   // status word: power outputs, fault latches, configured flag
   always_comb begin
      status_word = 8'h00;
      status_word[`DCPP_STAT_POWER_LSB +: PORTS] = port_power_out;
      status_word[`DCPP_STAT_FAULT_LSB +: PORTS] = fault;
      status_word[`DCPP_STAT_CONFIG_BIT]         = configured;
   end

   // registered read data; unmapped offsets read zero
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_rdata_q <= `DCPP_RDATA_RESET;
      end else if (cfg_rd_en) begin
         if (cfg_addr == `DCPP_CHARGE_EN_OFFSET) begin
            cfg_rdata_q <= charge_port_enable_mask_q;
         end else if (cfg_addr == `DCPP_STATUS_OFFSET) begin
            cfg_rdata_q <= status_word;
         end else begin
            cfg_rdata_q <= 8'h00;
         end
      end
   end

   // regulator enable: off in reset, on from the first edge after release
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         reg33_q <= 1'b0;
      end else begin
         reg33_q <= 1'b1;
      end
   end

   // one cell per port; role fixed by the mask once configured
   genvar gi;
   generate
      for (gi = 0; gi < PORTS; gi = gi + 1) begin : g_port
         assign role[gi] = configured &&
            charge_port_enable_mask_q[gi + `DCPP_FIRST_PORT_BIT];

         dcpp_port_cell u_cell (
            .core_clk               (core_clk),
            .reset_n                (reset_n),
            .configured             (configured),
            .charge_role            (role[gi]),
            .hub_port_power_feature (hub_port_power_feature[gi]),
            .hub_port_power_request (hub_port_power_request[gi]),
            .overcurrent_sense_n    (overcurrent_sense_n[gi]),
            .charge_query           (charge_query[gi]),
            .port_power_out         (port_power_out[gi]),
            .overcurrent_fault      (fault[gi]),
            .charge_ack             (charge_ack[gi])
         );
      end
   endgenerate

   assign cfg_rdata        = cfg_rdata_q;
   assign charge_port_role = role;
   assign reg33_enable     = reg33_q;

endmodule : dcpp_charge_port_ctrl

// ===== dcpp_charge_port_ctrl_chk.sv
// assertions on the charge port power control ports
`timescale 1ns/1ns
`include "dcpp_consts.svh"
module dcpp_charge_port_ctrl_chk #(parameter int PORTS = 3) (
   // clock, reset and register port
   input wire logic core_clk, reset_n, cfg_wr_en, cfg_rd_en, cfg_done,
   input wire logic [7:0] cfg_addr, cfg_wdata, cfg_rdata,
   // hub side, port pins and outputs
   input wire logic [PORTS-1:0] hub_port_power_feature,
   input wire logic [PORTS-1:0] hub_port_power_request,
   input wire logic [PORTS-1:0] overcurrent_sense_n, charge_query,
   input wire logic [PORTS-1:0] port_power_out, charge_ack,
   input wire logic [PORTS-1:0] charge_port_role,
   input wire logic reg33_enable
);
   logic cfg_q;
   logic [7:0] mask_q;
   logic [PORTS-1:0] flt_q, exp_w;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   // shadow of configured flag, mask and fault latches
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_q <= 1'h0;
         mask_q <= 8'h00;
         flt_q <= '0;
      end else begin
         cfg_q <= cfg_q | cfg_done;
         if (cfg_wr_en && !cfg_q && cfg_addr == `DCPP_CHARGE_EN_OFFSET)
            mask_q <= cfg_wdata;
         flt_q <= flt_q | (charge_port_role & ~hub_port_power_feature
            & ~overcurrent_sense_n);
      end
   end
   // power wanted one edge later
   assign exp_w = {PORTS{cfg_q}} & overcurrent_sense_n & ~flt_q
      & ((hub_port_power_feature & hub_port_power_request)
      | (~hub_port_power_feature & charge_port_role));
   a_power_owner: assert property (
      port_power_out == $past(exp_w)) else $error("power owner wrong");
   a_idle_unconfig: assert property (
      !cfg_q |-> port_power_out == '0 && charge_port_role == '0)
      else $error("power before configuration");
   a_role_mask: assert property (
      cfg_q |-> charge_port_role == mask_q[PORTS:1]) else $error("role bad");
   a_role_frozen: assert property (
      cfg_q && $past(cfg_q) |-> $stable(charge_port_role))
      else $error("role changed");
   a_fault_sticky: assert property (
      flt_q != '0 |=> (port_power_out & $past(flt_q)) == '0)
      else $error("faulted port powered");
   a_oc_cut: assert property (
      ~overcurrent_sense_n != '0 |=>
      (port_power_out & ~$past(overcurrent_sense_n)) == '0)
      else $error("overcurrent port powered");
   a_query_ack: assert property (
      charge_ack == $past(charge_query & charge_port_role))
      else $error("charge answer wrong");
   a_reg_on: assert property (
      $past(reset_n) |-> reg33_enable) else $error("regulator off");
endmodule : dcpp_charge_port_ctrl_chk

// ===== dcpp_far_side.sv
// far side model: downstream devices and upstream host
`timescale 1ns/1ns
module dcpp_far_side #(parameter int PORTS = 3) (
   // commands from the bench
   input wire logic enumerated,
   input wire logic [PORTS-1:0] host_power, trip, ask,
   // lines seen by the block
   output logic [PORTS-1:0] feature, request, oc_n, query
);
   // enumeration sets the power feature on all ports
   assign feature = {PORTS{enumerated}};
   // host switches power on itself once enumerated
   assign request = host_power & feature;
   // devices trip overcurrent and ask about charging
   assign oc_n = ~trip;
   assign query = ask;
endmodule : dcpp_far_side

// ===== dcpp_charge_port_ctrl_test.sv
// self-checking bench for the charge port power control
`timescale 1ns/1ns
`include "dcpp_consts.svh"
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin \
   errors++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module dcpp_charge_port_ctrl_test;
   logic core_clk, reset_n, wr, rd, done, enum_q, reg33;
   logic [7:0] addr, wdata, rdata, lfsr_q;
   logic [2:0] hpow, trip, ask, feat, req, ocn, qry, pow, ack, role;
   int errors, checks_done, m_mask, m_cfg, m_flt, m_pow, m_ack, m_role;
   int m_rd, m_reg;
   dcpp_charge_port_ctrl #(.PORTS(3)) dut_u (.core_clk(core_clk),
      .reset_n(reset_n), .cfg_wr_en(wr), .cfg_rd_en(rd), .cfg_addr(addr),
      .cfg_wdata(wdata), .cfg_rdata(rdata), .cfg_done(done),
      .hub_port_power_feature(feat), .hub_port_power_request(req),
      .overcurrent_sense_n(ocn), .charge_query(qry), .port_power_out(pow),
      .charge_ack(ack), .charge_port_role(role), .reg33_enable(reg33));
   dcpp_far_side #(.PORTS(3)) far_u (.enumerated(enum_q), .host_power(hpow),
      .trip(trip), .ask(ask), .feature(feat), .request(req), .oc_n(ocn),
      .query(qry));
   // clock
   initial begin
      core_clk = 1'h0;
      forever #4 core_clk = ~core_clk;
   end
   function automatic logic [7:0] lfsr_next(logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction : lfsr_next
   // reference model stepped at every rising edge
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         {m_mask, m_cfg, m_flt, m_pow, m_ack, m_role, m_rd, m_reg} = '0;
      end else begin
         if (rd) m_rd = addr == 8'hd0 ? m_mask : addr == `DCPP_STATUS_OFFSET
            ? m_cfg << 7 | m_flt << 4 | m_pow : 0;
         m_ack = qry & m_role;
         m_pow = m_cfg ? ocn & ~m_flt & (feat & req | ~feat & m_role) : 0;
         m_flt = m_flt | m_role & ~feat & ~ocn;
         if (wr && !m_cfg && addr == 8'hd0) m_mask = wdata & 8'hfe;
         m_cfg = m_cfg | done;
         m_role = m_cfg ? m_mask >> 1 & 7 : 0;
         m_reg = 1;
      end
   end
   // compare every output with the model once per cycle
   always @(negedge core_clk) begin
      `CHK("power", m_pow[2:0], pow)
      `CHK("ack", m_ack[2:0], ack)
      `CHK("role", m_role[2:0], role)
      `CHK("rdata", m_rd[7:0], rdata)
      `CHK("reg33", m_reg[0], reg33)
   end
   task automatic tick(int n);
      repeat (n) @(negedge core_clk);
   endtask : tick
   // one access of the serial configuration port
   task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
      @(negedge core_clk);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdata <= d;
      tick(1);
      wr <= 1'h0;
      rd <= 1'h0;
   endtask : acc
   task automatic summarize;
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : summarize
   // main sequence
   initial begin
      {reset_n, wr, rd, done, enum_q, addr, wdata, hpow, trip, ask} = '0;
      lfsr_q = lfsr_next(8'h5d);
      tick(4);
      reset_n <= 1'h1;
      acc(1, 8'hd0, lfsr_q & 8'hf9 | 8'h02);
      acc(0, 8'hd0, 8'h00);
      acc(1, 8'h42, 8'hff);
      acc(0, 8'h42, 8'h00);
      acc(0, 8'hd1, 8'h00);
      $display("registers done");
      done <= 1'h1;
      tick(1);
      done <= 1'h0;
      tick(3);
      acc(1, 8'hd0, 8'hff);
      acc(0, 8'hd0, 8'h00);
      $display("configure done");
      for (int i = 0; i < 20; i++) begin
         lfsr_q = lfsr_next(lfsr_q);
         ask <= lfsr_q[2:0];
         trip <= i > 9 && i < 12 ? 3'h1 : i == 16 ? 3'h4 : 3'h0;
         enum_q <= i > 13;
         hpow <= lfsr_q[6:4] | (i == 16 ? 3'h4 : 3'h0);
         tick(1);
      end
      acc(0, 8'hd1, 8'h00);
      $display("queries, fault and enumeration done");
      reset_n <= 1'h0;
      tick(2);
      reset_n <= 1'h1;
      done <= 1'h1;
      ask <= 3'h7;
      tick(1);
      done <= 1'h0;
      tick(4);
      acc(0, 8'hd1, 8'h00);
      $display("second reset done");
      summarize();
   end
   // watchdog
   initial begin
      #100000;
      errors++;
      summarize();
   end
endmodule : dcpp_charge_port_ctrl_test
bind dcpp_charge_port_ctrl dcpp_charge_port_ctrl_chk #(.PORTS(PORTS)) chk_u (
   .core_clk(core_clk), .reset_n(reset_n), .cfg_wr_en(cfg_wr_en),
   .cfg_rd_en(cfg_rd_en), .cfg_done(cfg_done), .cfg_addr(cfg_addr),
   .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
   .hub_port_power_feature(hub_port_power_feature),
   .hub_port_power_request(hub_port_power_request),
   .overcurrent_sense_n(overcurrent_sense_n), .charge_query(charge_query),
   .port_power_out(port_power_out), .charge_ack(charge_ack),
   .charge_port_role(charge_port_role), .reg33_enable(reg33_enable));
